// ### src/tcodf_defines.vh
// Purpose: constants for the thermostat output, defrost and alarm block
// Assumes: temperatures are signed tenths of a degree, 16 bits
// Notes:   mode codes are the values of the configuration ports
`ifndef TCODF_DEFINES_VH
`define TCODF_DEFINES_VH
`define TCODF_O1_OFF      4'h0
`define TCODF_O1_CTRL     4'h1
`define TCODF_O_ABS_HI    4'h2
`define TCODF_O_ABS_LO    4'h3
`define TCODF_O_REL_HI    4'h4
`define TCODF_O_REL_LO    4'h5
`define TCODF_O_REL_IN    4'h6
`define TCODF_O_REL_OUT   4'h7
`define TCODF_O_BIN_DIR   4'h8
`define TCODF_O2_BIN_INV  4'h9
`define TCODF_O2_DEFROST  4'hA
`define TCODF_DEF_OFF     2'h0
`define TCODF_DEF_PERIOD  2'h1
`define TCODF_DEF_MANUAL  2'h2
`define TCODF_BIN_NONE    3'h0
`define TCODF_BIN_STOP    3'h1
`define TCODF_BIN_CLEAR   3'h2
`define TCODF_BIN_OUT     3'h3
`define TCODF_BIN_DEFROST 3'h5
`define TCODF_FAIL_HALF   10'h1F4
`define TCODF_HYST_DEF    16'h000A
`define TCODF_DEV_DEF     16'h0014
`define TCODF_ASP_DEF     16'h0000
`define TCODF_SPL_DEF     16'hFE0C
`define TCODF_SPH_DEF     16'h03E8
`define TCODF_CLK_HZ      20000000
`define TCODF_HOUR_S      3600
`define TCODF_HOUR_CYC    37'h10C388D000
`endif

// ### src/tcodf_core.v
// Purpose: output selection, two-state regulation, defrost and alarms
// Assumes: temperatures signed tenths of a degree; PID duty from outside
// Notes:
// Notes on behaviour
// RULE1 - Output one selects off, regulation, absolute, relative or input follower.
// RULE2 - Output two: alarms, followers direct or inverted, defrost; never regulation.
// RULE3 - Regulation is two-state or PID, with cooling or heating sense.
// RULE4 - Defrost is disabled, periodic, or manual; disabled by default.
// RULE5 - Defrost ends by duration or by reaching the defrost temperature.
// RULE6 - Temperature end also cut off by the maximum duration.
// RULE7 - A failed sensor ends defrost only by duration.
// RULE8 - Defrost only when cooling and measured value below end temperature.
// RULE9 - A pending defrost waits until the value reaches the set point.
// RULE10 - Two-state with failed sensor: off at or below half, else on.
// RULE11 - Each alarm may latch; latched state stays after condition clears.
// RULE12 - Each alarm has its own hysteresis.
// RULE13 - Absolute alarms compare against a per-alarm threshold.
// RULE14 - Relative alarms compare against set point plus per-alarm deviation.
// RULE15 - Set point is clamped between low and high limits.
// RULE16 - Binary input in clear mode clears latched alarms.
// RULE17 - Binary input in stop mode makes regulation act as sensor failure.
// RULE18 - An alarm drops only after moving back by its hysteresis.
// RULE19 - Interval timer restarts at defrost end and counts whole hours.
`timescale 1ns/1ps
`include "tcodf_defines.vh"
module tcodf_alarm #(
  parameter W = 16
) (
  input  wire                clk_i,
  input  wire                rst_i,
  input  wire [3:0]          mode_i,
  input  wire signed [W-1:0] pv_i,
  input  wire signed [W-1:0] sp_i,
  input  wire signed [W-1:0] abs_i,
  input  wire signed [W-1:0] dev_i,
  input  wire signed [W-1:0] hyst_i,
  input  wire                latch_i,
  input  wire                clear_i,
  output reg                 alarm_q
);
  reg signed [W+1:0] hi_t;
  reg signed [W+1:0] lo_t;
  reg signed [W+1:0] pv;
  reg signed [W+1:0] hy;
  reg                on_c;
  reg                off_c;
  reg                alarm_d;
  always @* begin
    pv = pv_i;
    hy = hyst_i;
    hi_t = abs_i; // [RULE13]
    lo_t = abs_i;
    on_c = 1'b0;
    off_c = 1'b1;
    if (mode_i >= `TCODF_O_REL_HI) begin
      hi_t = sp_i + dev_i; // [RULE14]
      lo_t = sp_i - dev_i;
    end
    // Activate beyond the threshold, release one hysteresis back
    if (mode_i == `TCODF_O_ABS_HI || mode_i == `TCODF_O_REL_HI) begin
      on_c = pv > hi_t;
      off_c = pv <= hi_t - hy; // [RULE12] [RULE18]
    end else if (mode_i == `TCODF_O_ABS_LO || mode_i == `TCODF_O_REL_LO) begin
      on_c = pv < lo_t;
      off_c = pv >= lo_t + hy; // [RULE12] [RULE18]
    end else if (mode_i == `TCODF_O_REL_IN) begin
      on_c = (pv > lo_t) && (pv < hi_t);
      off_c = (pv <= lo_t - hy) || (pv >= hi_t + hy); // [RULE18]
    end else if (mode_i == `TCODF_O_REL_OUT) begin
      on_c = (pv > hi_t) || (pv < lo_t);
      off_c = (pv <= hi_t - hy) && (pv >= lo_t + hy); // [RULE18]
    end
    alarm_d = alarm_q;
    if (on_c)
      alarm_d = 1'b1;
    else if (off_c && !latch_i) // [RULE11]
      alarm_d = 1'b0;
    else if (clear_i && off_c) // [RULE16]
      alarm_d = 1'b0;
  end
  always @(posedge clk_i) begin
    if (rst_i)
      alarm_q <= 1'b0;
    else
      alarm_q <= alarm_d;
  end
endmodule

module tcodf_core #(
  parameter W         = 16,
  parameter HOUR_CYC  = `TCODF_HOUR_CYC,
  parameter HRW       = 8
) (
  input  wire                clk_i,
  input  wire                rst_i,
  input  wire signed [W-1:0] pv_i,
  input  wire                sensor_fail_i,
  input  wire                binary_in_i,
  input  wire [2:0]          binary_func_i,
  input  wire [3:0]          out1_mode_i,
  input  wire [3:0]          out2_mode_i,
  input  wire                algo_pid_i,
  input  wire                sense_heat_i,
  input  wire                pid_out_i,
  input  wire signed [W-1:0] hyst_i,
  input  wire signed [W-1:0] setpoint_i,
  input  wire signed [W-1:0] setpoint_low_limit_i,
  input  wire signed [W-1:0] setpoint_high_limit_i,
  input  wire [9:0]          fail_level_i,
  input  wire [1:0]          defrost_select_i,
  input  wire                defrost_by_temp_i,
  input  wire [HRW-1:0]      defrost_hours_i,
  input  wire signed [W-1:0] defrost_temp_i,
  input  wire [HRW-1:0]      defrost_interval_i,
  input  wire                manual_defrost_i,
  input  wire signed [W-1:0] a1_abs_i,
  input  wire signed [W-1:0] a1_dev_i,
  input  wire signed [W-1:0] a1_hyst_i,
  input  wire                a1_latch_i,
  input  wire signed [W-1:0] a2_abs_i,
  input  wire signed [W-1:0] a2_dev_i,
  input  wire signed [W-1:0] a2_hyst_i,
  input  wire                a2_latch_i,
  output reg                 out1_o,
  output reg                 out2_o,
  output reg                 defrost_active_o
);
  localparam S_IDLE = 3'b001;
  localparam S_WAIT = 3'b010;
  localparam S_RUN  = 3'b100;
  // Async pins pass two flops before use
  reg [1:0] bin_sync_q;
  reg [1:0] fail_sync_q;
  reg [1:0] man_sync_q;
  reg       man_prev_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      bin_sync_q  <= 2'b00;
      fail_sync_q <= 2'b00;
      man_sync_q  <= 2'b00;
      man_prev_q  <= 1'b0;
    end else begin
      bin_sync_q  <= {bin_sync_q[0], binary_in_i};
      fail_sync_q <= {fail_sync_q[0], sensor_fail_i};
      man_sync_q  <= {man_sync_q[0], manual_defrost_i};
      man_prev_q  <= man_sync_q[1];
    end
  end
  wire bin_q  = bin_sync_q[1];
  wire fail_q = fail_sync_q[1];
  wire bin_stop  = (binary_func_i == `TCODF_BIN_STOP) && bin_q;
  wire bin_clear = (binary_func_i == `TCODF_BIN_CLEAR) && bin_q;
  wire bin_def   = (binary_func_i == `TCODF_BIN_DEFROST) && bin_q;
  wire man_req   = (man_sync_q[1] && !man_prev_q) || bin_def;

  reg signed [W-1:0] sp;
  always @* begin
    sp = setpoint_i;
    if (setpoint_i < setpoint_low_limit_i)
      sp = setpoint_low_limit_i; // [RULE15]
    else if (setpoint_i > setpoint_high_limit_i)
      sp = setpoint_high_limit_i; // [RULE15]
  end

  // Two-state regulation: switches on one hysteresis past the set point, off at the set point
  reg onoff_q;
  reg onoff_d;
  wire signed [W:0] sp_hi = sp + hyst_i;
  wire signed [W:0] sp_lo = sp - hyst_i;
  always @* begin
    onoff_d = onoff_q;
    if (!sense_heat_i) begin // [RULE3]
      if (pv_i >= sp_hi)
        onoff_d = 1'b1;
      else if (pv_i <= sp)
        onoff_d = 1'b0;
    end else begin
      if (pv_i <= sp_lo)
        onoff_d = 1'b1;
      else if (pv_i >= sp)
        onoff_d = 1'b0;
    end
  end

  // Hour tick and defrost sequencer
  // One hour at 20 MHz needs 37 bits; a 32-bit count would wrap
  localparam [36:0] HOUR_LAST = HOUR_CYC - 1;
  reg [36:0]    hour_cnt_q;
  reg [HRW-1:0] int_hr_q;
  reg [HRW-1:0] run_hr_q;
  reg [2:0]     st_q;
  wire hour_tick = (hour_cnt_q == HOUR_LAST); // [RULE19]
  wire def_en    = !sense_heat_i; // [RULE8]
  wire below_end = pv_i < defrost_temp_i; // [RULE8]
  wire cycle_done = pv_i <= sp; // [RULE9]
  wire time_up   = run_hr_q >= defrost_hours_i;
  wire temp_end  = defrost_by_temp_i && !fail_q &&
                   (pv_i >= defrost_temp_i); // [RULE6] [RULE7]
  wire period_req = (defrost_select_i == `TCODF_DEF_PERIOD) &&
                    (int_hr_q >= defrost_interval_i);
  wire manual_req = (defrost_select_i == `TCODF_DEF_MANUAL) && man_req;
  always @(posedge clk_i) begin
    if (rst_i) begin
      hour_cnt_q <= 37'h0000000000;
      int_hr_q   <= {HRW{1'b0}};
      run_hr_q   <= {HRW{1'b0}};
      st_q       <= S_IDLE;
    end else begin
      hour_cnt_q <= hour_tick ? 37'h0000000000 : hour_cnt_q + 37'h0000000001;
      case (st_q)
        S_IDLE: begin
          if (hour_tick && int_hr_q != {HRW{1'b1}})
            int_hr_q <= int_hr_q + 1'b1;
          if (def_en && (period_req || manual_req)) // [RULE4] [RULE8]
            st_q <= S_WAIT;
        end
        S_WAIT: begin
          if (!def_en || defrost_select_i == `TCODF_DEF_OFF)
            st_q <= S_IDLE;
          else if (below_end && cycle_done) begin // [RULE8] [RULE9]
            st_q       <= S_RUN;
            run_hr_q   <= {HRW{1'b0}};
            hour_cnt_q <= 37'h0000000000; // Whole hours from run start
          end
        end
        S_RUN: begin
          if (hour_tick)
            run_hr_q <= run_hr_q + 1'b1;
          if (time_up || temp_end) begin // [RULE5] [RULE6] [RULE7]
            st_q       <= S_IDLE;
            int_hr_q   <= {HRW{1'b0}}; // [RULE19]
            hour_cnt_q <= 37'h0000000000; // [RULE19]
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
  wire defrosting = (st_q == S_RUN);

  // Failure or stop forces a fixed regulation level
  wire forced = fail_q || bin_stop; // [RULE17]
  wire forced_lvl = fail_level_i > `TCODF_FAIL_HALF; // [RULE10]
  wire reg_raw = algo_pid_i ? pid_out_i : onoff_q; // [RULE3]
  wire reg_out = forced ? forced_lvl : (defrosting ? 1'b0 : reg_raw);

  wire a1_q;
  wire a2_q;
  tcodf_alarm #(.W(W)) u_a1 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .mode_i  (out1_mode_i),
    .pv_i    (pv_i),
    .sp_i    (sp),
    .abs_i   (a1_abs_i),
    .dev_i   (a1_dev_i),
    .hyst_i  (a1_hyst_i),
    .latch_i (a1_latch_i),
    .clear_i (bin_clear),
    .alarm_q (a1_q)
  );
  tcodf_alarm #(.W(W)) u_a2 (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .mode_i  (out2_mode_i),
    .pv_i    (pv_i),
    .sp_i    (sp),
    .abs_i   (a2_abs_i),
    .dev_i   (a2_dev_i),
    .hyst_i  (a2_hyst_i),
    .latch_i (a2_latch_i),
    .clear_i (bin_clear),
    .alarm_q (a2_q)
  );

  reg out1_d;
  reg out2_d;
  always @* begin
    case (out1_mode_i) // [RULE1]
      `TCODF_O1_CTRL:   out1_d = reg_out;
      `TCODF_O_BIN_DIR: out1_d = bin_q;
      `TCODF_O_ABS_HI, `TCODF_O_ABS_LO, `TCODF_O_REL_HI,
      `TCODF_O_REL_LO, `TCODF_O_REL_IN, `TCODF_O_REL_OUT:
        out1_d = a1_q;
      default:          out1_d = 1'b0;
    endcase
    case (out2_mode_i) // [RULE2]
      `TCODF_O_BIN_DIR:  out2_d = bin_q;
      `TCODF_O2_BIN_INV: out2_d = !bin_q;
      `TCODF_O2_DEFROST: out2_d = defrosting;
      `TCODF_O_ABS_HI, `TCODF_O_ABS_LO, `TCODF_O_REL_HI,
      `TCODF_O_REL_LO, `TCODF_O_REL_IN, `TCODF_O_REL_OUT:
        out2_d = a2_q;
      default:           out2_d = 1'b0;
    endcase
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      onoff_q          <= 1'b0;
      out1_o           <= 1'b0;
      out2_o           <= 1'b0;
      defrost_active_o <= 1'b0;
    end else begin
      onoff_q          <= onoff_d;
      out1_o           <= out1_d;
      out2_o           <= out2_d;
      defrost_active_o <= defrosting;
    end
  end
endmodule

// ### testbench/tcodf_plant.sv
// Purpose: probe model feeding the measured value to the block
// Assumes: one-cycle settling of the probe reading
// Notes:   real probes lag far more; kept short to bound run time
`timescale 1ns/1ps
module tcodf_plant (
  input  wire               clk_i,
  input  wire               rst_i,
  input  wire signed [15:0] target_i,
  output reg  signed [15:0] pv_o
);
  always @(posedge clk_i) begin
    if (rst_i)
      pv_o <= 16'h0000;
    else
      pv_o <= target_i;
  end
endmodule

// ### testbench/tcodf_core_monitor.sv
// Purpose: timing relations on the block outputs
// Assumes: windows cover sync flops plus two output stages
// Notes:   bound to the core, ports only
`timescale 1ns/1ps
module tcodf_core_monitor (
  input wire               clk_i,
  input wire               rst_i,
  input wire signed [15:0] pv_i,
  input wire               sensor_fail_i,
  input wire [3:0]         out1_mode_i,
  input wire [3:0]         out2_mode_i,
  input wire               algo_pid_i,
  input wire               sense_heat_i,
  input wire [9:0]         fail_level_i,
  input wire signed [15:0] defrost_temp_i,
  input wire signed [15:0] a1_abs_i,
  input wire signed [15:0] a1_hyst_i,
  input wire               a1_latch_i,
  input wire               out1_o,
  input wire               out2_o,
  input wire               defrost_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_o2_reg; (out2_mode_i == 4'h1)[*3] |-> !out2_o; endproperty
  a_o2_reg: assert property (p_o2_reg) else $error("out2 regulates");
  property p_abs_on;
    (out1_mode_i == 4'h2 && pv_i > a1_abs_i)[*5] |-> out1_o; endproperty
  a_abs_on: assert property (p_abs_on) else $error("alarm1 missed");
  property p_abs_off; (out1_mode_i == 4'h2 && !a1_latch_i
    && pv_i <= a1_abs_i - a1_hyst_i)[*5] |-> !out1_o; endproperty
  a_abs_off: assert property (p_abs_off) else $error("alarm1 stuck");
  property p_fail_off; (out1_mode_i == 4'h1 && !algo_pid_i && sensor_fail_i
    && fail_level_i <= 10'h1F4)[*6] |-> !out1_o; endproperty
  a_fail_off: assert property (p_fail_off) else $error("fail not off");
  property p_fail_on; (out1_mode_i == 4'h1 && !algo_pid_i && sensor_fail_i
    && fail_level_i > 10'h1F4)[*6] |-> out1_o; endproperty
  a_fail_on: assert property (p_fail_on) else $error("fail not on");
  property p_def_heat; $rose(defrost_active_o) |-> !$past(sense_heat_i, 2);
  endproperty
  a_def_heat: assert property (p_def_heat) else $error("heat defrost");
  property p_def_temp;
    $rose(defrost_active_o) |-> $past(pv_i, 2) < $past(defrost_temp_i, 2);
  endproperty
  a_def_temp: assert property (p_def_temp) else $error("warm start");
  property p_def_o2;
    (out2_mode_i == 4'hA && defrost_active_o)[*3] |-> out2_o; endproperty
  a_def_o2: assert property (p_def_o2) else $error("out2 no defrost");
endmodule
bind tcodf_core tcodf_core_monitor i_tcodf_core_monitor (.*);

// ### testbench/tcodf_tb_top.sv
// Purpose: self-checking bench for the output, defrost and alarm core
// Assumes: hour shortened to HC cycles
// Notes:   notes queued by the driver, popped by the watcher
`timescale 1ns/1ps
`include "tcodf_defines.vh"
module tcodf_tb_top;
  localparam HC = 10;
  reg clk_i = 0, rst_i = 1, sensor_fail_i = 0, binary_in_i = 0;
  reg algo_pid_i = 0, sense_heat_i = 0, pid_out_i = 0, defrost_by_temp_i = 0;
  reg manual_defrost_i = 0, a1_latch_i = 0, a2_latch_i = 0;
  reg [2:0] binary_func_i = 3'h0;
  reg [3:0] out1_mode_i = 4'h2, out2_mode_i = 4'h4;
  reg [9:0] fail_level_i = 10'h000;
  reg [1:0] defrost_select_i = 2'h2;
  reg [7:0] defrost_hours_i = 8'h02, defrost_interval_i = 8'h0A;
  reg signed [15:0] target = 0, setpoint_i = 0, hyst_i = 16'h0014;
  reg signed [15:0] setpoint_low_limit_i = `TCODF_SPL_DEF;
  reg signed [15:0] setpoint_high_limit_i = `TCODF_SPH_DEF;
  reg signed [15:0] defrost_temp_i = 16'h003C, a1_abs_i = 16'h0064;
  reg signed [15:0] a1_dev_i = 16'h0014, a1_hyst_i = 16'h000A;
  reg signed [15:0] a2_abs_i = 0, a2_dev_i = 16'h0014, a2_hyst_i = 16'h0005;
  wire signed [15:0] pv_i;
  wire out1_o, out2_o, defrost_active_o;
  integer n_fail = 0, checks_done = 0, seed = 32'h1D98, i, k;
  reg [1:0] note_q[$];
  reg [1:0] note;
  reg st1 = 0, st2 = 0;
  event look;
  tcodf_core #(.HOUR_CYC(HC)) i_tcodf_core (.*);
  tcodf_plant i_tcodf_plant (.clk_i(clk_i), .rst_i(rst_i),
                             .target_i(target), .pv_o(pv_i));
  initial forever #25 clk_i = ~clk_i;
  task check(input [63:0] what, input exp, input got);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0s expected %b seen %b", what, exp, got);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task step(input signed [15:0] v, input e1, input e2);
    begin
      @(posedge clk_i);
      target <= v;
      repeat (7) @(posedge clk_i);
      note_q.push_back({e1, e2});
      -> look;
    end
  endtask
  task wait_def(input v, input integer lim, output integer n);
    begin
      n = 0;
      while (defrost_active_o !== v && n < lim) begin
        @(posedge clk_i);
        #1;
        n = n + 1;
      end
      if (n >= lim) begin
        check("timeout", 1'b0, 1'b1);
        results;
      end
    end
  endtask
  task req;
    begin
      @(posedge clk_i);
      manual_defrost_i <= 1'b1;
      repeat (4) @(posedge clk_i);
      manual_defrost_i <= 1'b0;
    end
  endtask
  always @(look) begin
    #1;
    note = note_q.pop_front();
    check("out1", note[1], out1_o);
    check("out2", note[0], out2_o);
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (i = 0; i < 24; i = i + 1) begin
      k = $random(seed) % 300;
      if (k > 100) st1 = 1'b1;
      else if (k <= 90) st1 = 1'b0;
      if (k > 20) st2 = 1'b1;
      else if (k <= 15) st2 = 1'b0;
      step(k[15:0], st1, st2);
    end
    setpoint_i <= 16'h07D0;
    step(16'h0406, 1'b1, 1'b1);
    setpoint_i <= 16'h0000;
    step(16'h0000, 1'b0, 1'b0);
    a1_latch_i <= 1'b1;
    step(16'h0096, 1'b1, 1'b1);
    step(16'h0000, 1'b1, 1'b0);
    binary_func_i <= `TCODF_BIN_CLEAR;
    binary_in_i <= 1'b1;
    step(16'h0000, 1'b0, 1'b0);
    a1_latch_i <= 1'b0;
    out1_mode_i <= `TCODF_O_BIN_DIR;
    out2_mode_i <= `TCODF_O2_BIN_INV;
    binary_func_i <= `TCODF_BIN_OUT;
    for (i = 0; i < 2; i = i + 1) begin
      binary_in_i <= i[0];
      step(16'h0000, i[0], !i[0]);
    end
    out1_mode_i <= `TCODF_O1_CTRL;
    out2_mode_i <= `TCODF_O1_CTRL;
    binary_func_i <= `TCODF_BIN_STOP;
    binary_in_i <= 1'b0;
    step(16'h0028, 1'b1, 1'b0);
    step(16'h000A, 1'b1, 1'b0);
    step(16'h0000, 1'b0, 1'b0);
    sense_heat_i <= 1'b1;
    step(16'hFFD8, 1'b1, 1'b0);
    algo_pid_i <= 1'b1;
    pid_out_i <= 1'b1;
    step(16'h0000, 1'b1, 1'b0);
    {algo_pid_i, pid_out_i, sense_heat_i, sensor_fail_i} <= 4'h1;
    fail_level_i <= 10'h1F4;
    step(16'h0028, 1'b0, 1'b0);
    fail_level_i <= 10'h1F5;
    step(16'h0000, 1'b1, 1'b0);
    sensor_fail_i <= 1'b0;
    binary_in_i <= 1'b1;
    step(16'hFF9C, 1'b1, 1'b0);
    binary_in_i <= 1'b0;
    fail_level_i <= 10'h000;
    out2_mode_i <= `TCODF_O2_DEFROST;
    step(16'hFF9C, 1'b0, 1'b0);
    req;
    wait_def(1'b1, 20, k);
    wait_def(1'b0, 60, k);
    check("dur", 1'b1, k >= 2*HC-3 && k <= 2*HC+3);
    defrost_by_temp_i <= 1'b1;
    defrost_hours_i <= 8'h05;
    req;
    wait_def(1'b1, 20, k);
    target <= 16'h0046;
    wait_def(1'b0, 20, k);
    target <= 16'hFF9C;
    req;
    wait_def(1'b1, 20, k);
    sensor_fail_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    target <= 16'h0046;
    wait_def(1'b0, 80, k);
    check("dfail", 1'b1, k >= 5*HC-5);
    sensor_fail_i <= 1'b0;
    target <= 16'h000A;
    req;
    repeat (12) @(posedge clk_i);
    check("pend", 1'b0, defrost_active_o);
    target <= 16'hFF9C;
    wait_def(1'b1, 20, k);
    wait_def(1'b0, 80, k);
    defrost_select_i <= `TCODF_DEF_PERIOD;
    wait_def(1'b1, 150, k);
    defrost_select_i <= `TCODF_DEF_MANUAL;
    wait_def(1'b0, 80, k);
    sense_heat_i <= 1'b1;
    req;
    repeat (12) @(posedge clk_i);
    check("heat", 1'b0, defrost_active_o);
    results;
  end
endmodule
